/* logic/ltwd_pkg.sv */
// ltwd_pkg: register map, field layout and reset values of the local timer block
package ltwd_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_USER_COUNT_LO = 12'h000;
   localparam logic [11:0] OFS_LOCAL_PEND = 12'h004;
   localparam logic [11:0] OFS_LOCAL_MASK = 12'h008;
   localparam logic [11:0] OFS_MASK_CLEAR = 12'h00C;
   localparam logic [11:0] OFS_MASK_SET = 12'h010;
   localparam logic [11:0] OFS_USER_COUNT_HI = 12'h020;
   localparam logic [11:0] OFS_WD_ROUTE = 12'h040;
   localparam logic [11:0] OFS_WD_CONTROL = 12'h090;
   localparam logic [11:0] OFS_WD_COUNT = 12'h094;
   localparam logic [11:0] OFS_WD_RELOAD = 12'h098;
   localparam logic [11:0] OFS_GLOBAL_CFG = 12'h100;
   localparam logic [11:0] OFS_SHARED_LO = 12'h110;
   localparam logic [11:0] OFS_SHARED_HI = 12'h114;
   localparam logic [11:0] OFS_COMPARE_LO = 12'h120;
   localparam logic [11:0] OFS_COMPARE_HI = 12'h124;

   // global configuration fields
   localparam int CFG_HALT_BIT = 28;
   localparam int CFG_WCODE_LSB = 8;
   localparam logic [3:0] WCODE_RESET = 4'h8;
   localparam logic [3:0] WCODE_MAX = 4'h8;
   localparam logic [6:0] WIDTH_MIN = 7'h20;

   // local interrupt bit positions
   localparam int PEND_WD_BIT = 0;
   localparam int PEND_INTERVAL_BIT = 1;

   // watchdog modes
   typedef enum logic [2:0] {
      WD_ONE_TRIP = 3'b000,
      WD_SECOND = 3'b001,
      WD_PERIODIC = 3'b010
   } ltwd_mode_t;

   // watchdog control layout: bit0 run, 3:1 mode, 4 wait continue, 5 debug continue
   typedef struct packed {
      logic [25:0] rsvd;
      logic debugCont;
      logic waitCont;
      logic [2:0] mode;
      logic run;
   } ltwd_ctl_t;
   localparam ltwd_ctl_t CTL_RESET = 32'h0000_0000;

   // route select layout: 31 to line, 30 to nonmaskable, 5:0 map
   typedef struct packed {
      logic toLine;
      logic toNmi;
      logic [23:0] rsvd;
      logic [5:0] map;
   } ltwd_route_t;
   localparam ltwd_route_t ROUTE_RESET = 32'h0000_0000;
   localparam logic [5:0] LINE_COUNT = 6'h06;
endpackage : ltwd_pkg

/* logic/ltwd_timers.sv */
// ltwd_timers: shared interval counter, compare interrupt and local watchdog
// What this block does
// [RULE1] software halts the shared counter before writing a new count into it
// [RULE2] shared count is readable, read-only, at user-visible offset zero
// [RULE3] counter width is 32 plus four times the width code
// [RULE4] width code resets to 8, giving a 64-bit counter
// [RULE5] compare writable anytime; interval interrupt when count equals compare
// [RULE6] a compare write clears the pending interval interrupt, except in a cycle where count equals compare
// [RULE7] wait-continue clear pauses the watchdog during wait or low power
// [RULE8] debug-continue clear pauses the watchdog during debug mode
// [RULE9] control bits 3:1 choose the action at zero
// [RULE10] mode 0: interrupt and stop at zero
// [RULE11] mode 1: interrupt and reload, second expiry resets all processors
// [RULE12] mode 2: interrupt, reload and keep counting each time
// [RULE13] counts only while run set; writing run 1 reloads the count
// [RULE14] software clears run, writes reload value, then sets run
// [RULE15] current count register is read-only and shows the down-counter
// [RULE16] watchdog interrupt sets pending bit 0 at offset 4
// [RULE17] pending watchdog interrupt forwarded only while mask bit 0 set
// [RULE18] set-mask bit 0 at 0x10 enables, clear-mask bit 0 at 0xC disables
// [RULE19] watchdog system reset ignores the mask bit
// [RULE20] route register at 0x40 picks interrupt line or nonmaskable input
// [RULE21] non-external mode: map value n drives line n, 0 to 5 valid
// [RULE22] external mode: map value driven as binary code on six lines
// [RULE23] bit 31 routes to line, bit 30 to nonmaskable, never both
// [RULE24] shared counter increments each clock while not halted, wraps at width
// [RULE25] watchdog decrements each clock while running and not paused
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module ltwd_timers
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic cpuWait,
   input wire logic cpuLowPower,
   input wire logic cpuDebug,
   input wire logic eicMode,
   output logic [5:0] intLines,
   output logic nmiOut,
   output logic systemResetOut,
   output logic intervalIrq
);
   import ltwd_pkg::*;

   logic ackFf;
   logic [31:0] rdataFf;
   logic [31:0] cfgFf;
   logic [63:0] sharedCntFf;
   logic [63:0] compareFf;
   logic intervalPendFf;
   ltwd_ctl_t ctlFf;
   ltwd_route_t routeFf;
   logic [31:0] wdCntFf;
   logic [31:0] wdReloadFf;
   logic secondFf;
   logic wdPendFf;
   logic maskFf;
   logic sysRstFf;
   logic [5:0] linesFf;
   logic nmiFf;

   logic wrEn;
   logic [31:0] rdata;
   logic [3:0] effCode;
   logic [6:0] shiftAmt;
   logic [63:0] widthMask;
   logic halted;
   logic match;
   logic wrCompare;
   logic runLoad;
   logic wrCtl;
   logic wdPaused;
   logic wdStep;
   logic expire;
   ltwd_mode_t curMode;
   logic isOneTrip;
   logic finalExpiry;
   logic wdEvent;
   logic forward;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
   assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ~ackFf;
   assign wb_ack_o = ackFf;
   assign wb_dat_o = rdataFf;

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         ackFf <= 1'b0;
         rdataFf <= 32'h0000_0000;
      end
      else
      begin
         ackFf <= wb_cyc_i & wb_stb_i & ~ackFf;
         rdataFf <= rdata;
      end
   end

   always_comb
   begin
      rdata = 32'h0000_0000;
      case (wb_adr_i)
         OFS_USER_COUNT_LO: rdata = sharedCntFf[31:0]; // see [RULE2]
         OFS_USER_COUNT_HI: rdata = sharedCntFf[63:32];
         OFS_LOCAL_PEND:
         begin
            rdata[PEND_WD_BIT] = wdPendFf;
            rdata[PEND_INTERVAL_BIT] = intervalPendFf;
         end
         OFS_LOCAL_MASK: rdata[PEND_WD_BIT] = maskFf;
         OFS_WD_ROUTE: rdata = routeFf;
         OFS_WD_CONTROL: rdata = ctlFf;
         OFS_WD_COUNT: rdata = wdCntFf; // see [RULE15]
         OFS_WD_RELOAD: rdata = wdReloadFf;
         OFS_GLOBAL_CFG: rdata = cfgFf;
         OFS_SHARED_LO: rdata = sharedCntFf[31:0];
         OFS_SHARED_HI: rdata = sharedCntFf[63:32];
         OFS_COMPARE_LO: rdata = compareFf[31:0];
         OFS_COMPARE_HI: rdata = compareFf[63:32];
         default: rdata = 32'h0000_0000;
      endcase
   end

   // global configuration: halt bit and width code
   always_ff @(posedge clock)
   begin
      if (!rstn)
         cfgFf <= {20'h00000, WCODE_RESET, 8'h00}; // see [RULE4]
      else if (wrEn && wb_adr_i == OFS_GLOBAL_CFG)
         cfgFf <= merge(cfgFf, wb_dat_i, wb_sel_i) & 32'h1000_0F00;
   end

   // counter width from the width code, codes above 8 act as 8
   assign effCode = (cfgFf[CFG_WCODE_LSB +: 4] > WCODE_MAX) ? WCODE_MAX
                    : cfgFf[CFG_WCODE_LSB +: 4];
   assign shiftAmt = WIDTH_MIN - {effCode, 2'b00}; // see [RULE3]
   assign widthMask = 64'hFFFF_FFFF_FFFF_FFFF >> shiftAmt;
   assign halted = cfgFf[CFG_HALT_BIT];

   // shared counter; writes are expected only while halted
   always_ff @(posedge clock)
   begin
      if (!rstn)
         sharedCntFf <= 64'h0000_0000_0000_0000;
      else if (wrEn && wb_adr_i == OFS_SHARED_LO)
         sharedCntFf[31:0] <= merge(sharedCntFf[31:0], wb_dat_i, wb_sel_i) & widthMask[31:0];
      else if (wrEn && wb_adr_i == OFS_SHARED_HI)
         sharedCntFf[63:32] <= merge(sharedCntFf[63:32], wb_dat_i, wb_sel_i)
                               & widthMask[63:32]; // see [RULE1]
      else if (!halted)
         sharedCntFf <= (sharedCntFf + 64'h1) & widthMask; // see [RULE24]
   end

   // compare register and interval interrupt
   assign wrCompare = wrEn && (wb_adr_i == OFS_COMPARE_LO || wb_adr_i == OFS_COMPARE_HI);
   assign match = ((sharedCntFf & widthMask) == (compareFf & widthMask));
   assign intervalIrq = intervalPendFf;

   always_ff @(posedge clock)
   begin
      if (!rstn)
         compareFf <= 64'hFFFF_FFFF_FFFF_FFFF;
      else if (wrEn && wb_adr_i == OFS_COMPARE_LO)
         compareFf[31:0] <= merge(compareFf[31:0], wb_dat_i, wb_sel_i);
      else if (wrEn && wb_adr_i == OFS_COMPARE_HI)
         compareFf[63:32] <= merge(compareFf[63:32], wb_dat_i, wb_sel_i);
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         intervalPendFf <= 1'b0;
      else if (match)
         intervalPendFf <= 1'b1; // see [RULE5]
      else if (wrCompare)
         intervalPendFf <= 1'b0; // see [RULE6]
   end

   // watchdog step and expiry
   assign wrCtl = wrEn && wb_adr_i == OFS_WD_CONTROL;
   assign runLoad = wrCtl && wb_sel_i[0] && wb_dat_i[0];
   assign wdPaused = (cpuDebug && !ctlFf.debugCont) // see [RULE8]
                     || ((cpuWait || cpuLowPower) && !ctlFf.waitCont); // see [RULE7]
   assign wdStep = ctlFf.run && !wdPaused && !runLoad; // see [RULE13]
   assign expire = wdStep && wdCntFf == 32'h0000_0000;
   assign curMode = ltwd_mode_t'(ctlFf.mode); // see [RULE9]
   assign isOneTrip = curMode != WD_SECOND && curMode != WD_PERIODIC;
   assign finalExpiry = expire && curMode == WD_SECOND && secondFf;
   assign wdEvent = expire && !finalExpiry;

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         ctlFf <= CTL_RESET;
      end
      else if (wrCtl)
      begin
         ctlFf <= merge(ctlFf, wb_dat_i, wb_sel_i) & 32'h0000_003F;
      end
      else if (expire && isOneTrip)
      begin
         ctlFf.run <= 1'b0; // see [RULE10]
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
         wdReloadFf <= 32'h0000_0000;
      else if (wrEn && wb_adr_i == OFS_WD_RELOAD)
         wdReloadFf <= merge(wdReloadFf, wb_dat_i, wb_sel_i); // see [RULE14]
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         wdCntFf <= 32'h0000_0000;
      end
      else if (runLoad)
      begin
         wdCntFf <= wdReloadFf; // see [RULE13]
      end
      else if (expire && !isOneTrip)
      begin
         wdCntFf <= wdReloadFf; // see [RULE11] see [RULE12]
      end
      else if (wdStep && !expire)
      begin
         wdCntFf <= wdCntFf - 32'h0000_0001; // see [RULE25]
      end
   end

   // second-countdown tracking and system reset
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         secondFf <= 1'b0;
      end
      else if (runLoad)
      begin
         secondFf <= 1'b0;
      end
      else if (expire && curMode == WD_SECOND)
      begin
         secondFf <= 1'b1; // see [RULE11]
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         sysRstFf <= 1'b0;
      end
      else if (finalExpiry)
      begin
         sysRstFf <= 1'b1; // see [RULE11] see [RULE19]
      end
   end
   assign systemResetOut = sysRstFf;

   // local pending and mask
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         wdPendFf <= 1'b0;
      end
      else if (wdEvent)
      begin
         wdPendFf <= 1'b1; // see [RULE16]
      end
      else if (runLoad)
      begin
         wdPendFf <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         maskFf <= 1'b0;
      end
      else if (wrEn && wb_adr_i == OFS_MASK_SET && wb_sel_i[0] && wb_dat_i[PEND_WD_BIT])
      begin
         maskFf <= 1'b1; // see [RULE18]
      end
      else if (wrEn && wb_adr_i == OFS_MASK_CLEAR && wb_sel_i[0] && wb_dat_i[PEND_WD_BIT])
      begin
         maskFf <= 1'b0; // see [RULE18]
      end
   end

   // route select and output pins
   always_ff @(posedge clock)
   begin
      if (!rstn)
         routeFf <= ROUTE_RESET;
      else if (wrEn && wb_adr_i == OFS_WD_ROUTE)
         routeFf <= merge(routeFf, wb_dat_i, wb_sel_i) & 32'hC000_003F;
   end

   assign forward = wdPendFf && maskFf; // see [RULE17]

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         linesFf <= 6'h00;
         nmiFf <= 1'b0;
      end
      else
      begin
         linesFf <= 6'h00;
         if (forward && routeFf.toLine) // see [RULE20] see [RULE23]
         begin
            if (eicMode)
            begin
               linesFf <= routeFf.map; // see [RULE22]
            end
            else if (routeFf.map < LINE_COUNT)
            begin
               linesFf <= 6'h01 << routeFf.map; // see [RULE21]
            end
         end
         nmiFf <= forward && routeFf.toNmi && !routeFf.toLine; // see [RULE23]
      end
   end
   assign intLines = linesFf;
   assign nmiOut = nmiFf;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_counter_increment: assert property (!halted && !wrEn && !$past(wrEn) |=> // see [RULE24]
      sharedCntFf == (($past(sharedCntFf) + 64'h1) & $past(widthMask)))
      else $error("shared counter did not advance");
   a_interval_raise: assert property (match |=> intervalIrq) // see [RULE5]
      else $error("interval interrupt missing on match");
   a_interval_clear: assert property (wrCompare && !match |=> !intervalIrq) // see [RULE6]
      else $error("compare write did not clear interval interrupt");
   a_run_reload: assert property (runLoad |=> wdCntFf == $past(wdReloadFf)) // see [RULE13]
      else $error("run write did not reload count");
   a_wd_decrement: assert property (wdStep && wdCntFf != 32'h0 |=> // see [RULE25]
      wdCntFf == $past(wdCntFf) - 32'h1)
      else $error("watchdog did not decrement");
   a_debug_pause: assert property (cpuDebug && !ctlFf.debugCont && !runLoad |=> // see [RULE8]
      $stable(wdCntFf))
      else $error("watchdog counted in debug mode");
   a_wait_pause: assert property ((cpuWait || cpuLowPower) && !ctlFf.waitCont // see [RULE7]
      && !runLoad |=> $stable(wdCntFf))
      else $error("watchdog counted in low power");
   a_one_trip_stop: assert property (expire && isOneTrip && !wrCtl |=> // see [RULE10]
      !ctlFf.run && wdPendFf)
      else $error("one-trip expiry did not stop");
   a_second_reset: assert property (finalExpiry |=> // see [RULE11]
      systemResetOut ##1 systemResetOut)
      else $error("second expiry did not reset system");
   a_mask_gates: assert property (!maskFf |=> !nmiOut && intLines == 6'h00) // see [RULE17]
      else $error("masked interrupt reached a pin");
   a_pend_set: assert property (wdEvent |=> wdPendFf) // see [RULE16]
      else $error("pending bit not set on expiry");
endmodule : ltwd_timers

/* bench/ltwd_core_model.sv */
// ltwd_core_model: processor core state lines and nonmaskable input seen by the timers
`timescale 1ns/1ps
module ltwd_core_model
(
   input wire logic clock,
   input wire logic nmiOut,
   input wire logic systemResetOut,
   output logic cpuWait,
   output logic cpuLowPower,
   output logic cpuDebug,
   output logic [7:0] nmiTaken
);
   logic nmiPrev;
   initial
   begin
      cpuWait = 1'b0;
      cpuLowPower = 1'b0;
      cpuDebug = 1'b0;
      nmiTaken = 8'h00;
      nmiPrev = 1'b0;
   end
   // core state changes only at a clock edge
   task automatic setState(input logic [2:0] st);
   begin
      @(posedge clock);
      cpuWait <= st[2];
      cpuLowPower <= st[1];
      cpuDebug <= st[0];
   end
   endtask : setState
   // core takes a nonmaskable request on its rising level unless held in reset
   always @(posedge clock)
   begin
      nmiPrev <= nmiOut;
      if (nmiOut && !nmiPrev && !systemResetOut)
         nmiTaken <= nmiTaken + 8'h01;
   end
endmodule : ltwd_core_model

/* bench/ltwd_timers_tb.sv */
// ltwd_timers_tb: self-checking bench for the local timer block
`timescale 1ns/1ps
module ltwd_timers_tb;
   import ltwd_pkg::*;
   logic clock, rstn, wbCyc, wbStb, wbWe, wbAck, eicMode;
   logic cpuWait, cpuLowPower, cpuDebug, nmiOut, systemResetOut, intervalIrq;
   logic [11:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatI, wbDatO, rdData, c1;
   logic [5:0] intLines;
   logic [7:0] nmiTaken;
   int miscompares, checked, cycles;
   ltwd_timers uut (.clock(clock), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .cpuWait(cpuWait), .cpuLowPower(cpuLowPower),
      .cpuDebug(cpuDebug), .eicMode(eicMode), .intLines(intLines), .nmiOut(nmiOut),
      .systemResetOut(systemResetOut), .intervalIrq(intervalIrq));
   ltwd_core_model core (.clock(clock), .nmiOut(nmiOut), .systemResetOut(systemResetOut),
      .cpuWait(cpuWait), .cpuLowPower(cpuLowPower), .cpuDebug(cpuDebug),
      .nmiTaken(nmiTaken));
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic stop_test;
   begin
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask : stop_test
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         stop_test();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
   begin
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   end
   endtask : check
   // classic single cycle, held until ack is seen, released at the ack edge
   task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
   begin
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatI <= dat;
      wbSel <= 4'hF;
      @(posedge clock);
      while (wbAck !== 1'b1)
         @(posedge clock);
      rdData = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   end
   endtask : bus
   task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
   begin
      bus(1'b1, adr, dat);
   end
   endtask : wr
   task automatic rd(input logic [11:0] adr);
   begin
      bus(1'b0, adr, 32'h0000_0000);
   end
   endtask : rd
   task automatic waitCycles(input int n);
   begin
      repeat (n) @(posedge clock);
      @(negedge clock);
   end
   endtask : waitCycles
   task automatic doReset;
   begin
      @(posedge clock);
      rstn <= 1'b0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
   end
   endtask : doReset
   task automatic testResetValues;
   begin
      rd(OFS_GLOBAL_CFG);
      check("widthCode", rdData, 32'h0000_0800);
      rd(OFS_LOCAL_MASK);
      check("maskState", rdData, 32'h0000_0000);
      rd(OFS_WD_CONTROL);
      check("wdControl", rdData, 32'h0000_0000);
      rd(12'h0FC);
      check("unmapped", rdData, 32'h0000_0000);
   end
   endtask : testResetValues
   task automatic testShared;
      logic [31:0] cfg[2] = '{32'h0000_0800, 32'h0000_0000};
      logic [31:0] hi[2] = '{32'h0000_0001, 32'h0000_0000};
   begin
      for (int i = 0; i < 2; i++)
      begin
         wr(OFS_GLOBAL_CFG, cfg[i] | 32'h1000_0000);
         wr(OFS_SHARED_LO, 32'hFFFF_FFF0);
         wr(OFS_SHARED_HI, 32'h0000_0000);
         wr(OFS_USER_COUNT_LO, 32'h0000_0000);
         rd(OFS_USER_COUNT_LO);
         check("userCount", rdData, 32'hFFFF_FFF0);
         wr(OFS_GLOBAL_CFG, cfg[i]);
         rd(OFS_SHARED_LO);
         c1 = rdData;
         rd(OFS_SHARED_LO);
         check("countStep", rdData, c1 + 32'h3);
         waitCycles(60);
         rd(OFS_SHARED_HI);
         check("countHigh", rdData, hi[i]);
      end
      wr(OFS_GLOBAL_CFG, 32'h0000_0800);
   end
   endtask : testShared
   task automatic testCompare;
   begin
      wr(OFS_GLOBAL_CFG, 32'h1000_0800);
      wr(OFS_SHARED_LO, 32'h0000_0000);
      wr(OFS_SHARED_HI, 32'h0000_0000);
      wr(OFS_COMPARE_LO, 32'h0000_0040);
      wr(OFS_COMPARE_HI, 32'h0000_0000);
      wr(OFS_GLOBAL_CFG, 32'h0000_0800);
      waitCycles(90);
      check("intervalIrq", {31'h0, intervalIrq}, 32'h1);
      rd(OFS_LOCAL_PEND);
      check("pendInterval", rdData, 32'h0000_0002);
      wr(OFS_COMPARE_LO, 32'hFFFF_FFFF);
      check("irqCleared", {31'h0, intervalIrq}, 32'h0);
   end
   endtask : testCompare
   task automatic testOneTrip;
      logic [31:0] route[2] = '{32'h8000_0002, 32'h4000_0000};
      logic [31:0] pins[2] = '{32'h0000_0008, 32'h0000_0001};
   begin
      for (int i = 0; i < 2; i++)
      begin
         wr(OFS_WD_CONTROL, 32'h0000_0000);
         wr(OFS_WD_RELOAD, 32'd10);
         wr(OFS_WD_ROUTE, route[i]);
         wr(OFS_WD_CONTROL, 32'h0000_0001);
         wr(OFS_MASK_SET, 32'h0000_0001);
         waitCycles(30);
         check("pins", {25'h0, intLines, nmiOut}, pins[i]);
         rd(OFS_LOCAL_PEND);
         check("pendWd", rdData, 32'h0000_0001);
         rd(OFS_WD_COUNT);
         check("wdCount", rdData, 32'h0000_0000);
         rd(OFS_WD_CONTROL);
         check("runCleared", rdData, 32'h0000_0000);
         wr(OFS_MASK_CLEAR, 32'h0000_0001);
         rd(OFS_LOCAL_MASK);
         check("maskOff", rdData, 32'h0000_0000);
         check("pinsOff", {25'h0, intLines, nmiOut}, 32'h0);
      end
      check("nmiTaken", {24'h0, nmiTaken}, 32'h1);
   end
   endtask : testOneTrip
   task automatic testPeriodic;
   begin
      wr(OFS_WD_CONTROL, 32'h0000_0000);
      wr(OFS_WD_RELOAD, 32'd40);
      wr(OFS_WD_ROUTE, 32'h8000_0000);
      wr(OFS_WD_CONTROL, 32'h0000_0005);
      wr(OFS_MASK_SET, 32'h0000_0001);
      waitCycles(100);
      rd(OFS_WD_CONTROL);
      check("stillRun", rdData, 32'h0000_0005);
      rd(OFS_WD_COUNT);
      check("reloaded", {31'h0, rdData <= 32'd40}, 32'h1);
      check("line0", {26'h0, intLines}, 32'h1);
      wr(OFS_WD_CONTROL, 32'h0000_0000);
      wr(OFS_MASK_CLEAR, 32'h0000_0001);
   end
   endtask : testPeriodic
   task automatic testPause;
      logic [2:0] st[3] = '{3'b100, 3'b010, 3'b001};
      logic [31:0] cont[3] = '{32'h11, 32'h11, 32'h21};
   begin
      for (int i = 0; i < 3; i++)
      begin
         core.setState(st[i]);
         wr(OFS_WD_RELOAD, 32'd1000);
         wr(OFS_WD_CONTROL, 32'h0000_0001);
         rd(OFS_WD_COUNT);
         check("loadPaused", rdData, 32'd1000);
         rd(OFS_WD_COUNT);
         check("stayPaused", rdData, 32'd1000);
         wr(OFS_WD_CONTROL, cont[i]);
         rd(OFS_WD_COUNT);
         c1 = rdData;
         rd(OFS_WD_COUNT);
         check("contStep", rdData, c1 - 32'h3);
      end
      wr(OFS_WD_CONTROL, 32'h0000_0000);
      core.setState(3'b000);
   end
   endtask : testPause
   task automatic testEncoded;
   begin
      @(posedge clock);
      eicMode <= 1'b1;
      wr(OFS_WD_RELOAD, 32'd5);
      wr(OFS_WD_ROUTE, 32'h8000_002A);
      wr(OFS_WD_CONTROL, 32'h0000_0001);
      wr(OFS_MASK_SET, 32'h0000_0001);
      waitCycles(20);
      check("encoded", {26'h0, intLines}, 32'h2A);
      @(posedge clock);
      eicMode <= 1'b0;
      wr(OFS_WD_ROUTE, 32'h8000_0006);
      waitCycles(4);
      check("badMap", {26'h0, intLines}, 32'h0);
      wr(OFS_MASK_CLEAR, 32'h0000_0001);
   end
   endtask : testEncoded
   task automatic testSecond;
   begin
      wr(OFS_WD_CONTROL, 32'h0000_0000);
      wr(OFS_WD_RELOAD, 32'd20);
      wr(OFS_WD_ROUTE, 32'h4000_0000);
      wr(OFS_WD_CONTROL, 32'h0000_0003);
      waitCycles(25);
      rd(OFS_LOCAL_PEND);
      check("firstExpiry", {30'h0, systemResetOut, rdData[0]}, 32'h1);
      waitCycles(40);
      check("sysReset", {30'h0, systemResetOut, nmiOut}, 32'h2);
      doReset();
      waitCycles(1);
      check("resetGone", {31'h0, systemResetOut}, 32'h0);
   end
   endtask : testSecond
   initial
   begin
      rstn = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 12'h000;
      wbSel = 4'h0;
      wbDatI = 32'h0000_0000;
      eicMode = 1'b0;
      doReset();
      testResetValues();
      testShared();
      testCompare();
      testOneTrip();
      testPeriodic();
      testPause();
      testEncoded();
      testSecond();
      stop_test();
   end
endmodule : ltwd_timers_tb
